// ===== inc/angle_output_pkg.sv
package angle_output_pkg;

    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_PERIOD_NS = 10;
    localparam int PWM_PERIOD_NS = 750000;
    localparam int PWM_ZERO_HIGH = 16;
    localparam int PWM_LOW_SPAN = 359;
    localparam int PWM_EXIT = 8;
    localparam int PWM_ERR_HIGH = 12;
    localparam int PWM_FRAME = PWM_ZERO_HIGH + PWM_LOW_SPAN + PWM_EXIT;
    // Longest step that keeps the frame within its nominal period: round down
    localparam int PWM_STEP_CYC = PWM_PERIOD_NS / (PWM_FRAME * CLK_PERIOD_NS);
    localparam int EXT_SYNC_CYCLES = 4;

    // ****************************************
    // Angle and output encoding
    // ****************************************
    localparam int ANGLE_STEPS = 360;
    localparam int ELEC_HALF = 180;
    localparam int ELEC_THIRD = 120;
    localparam int ELEC_SIXTH = 60;
    localparam int ELEC_TWO_THIRD = 240;
    localparam int ELEC_FIVE_SIXTH = 300;
    localparam int INDEX_WIDTH = 2;
    localparam int STEP_PER_24 = 15;
    localparam int STEP_PER_60 = 6;
    localparam int STEP_PER_90 = 4;
    localparam int STEP_PER_180 = 2;
    localparam int MAX_POLE_PAIRS = 6;

    // ****************************************
    // Stored configuration word layout
    // ****************************************
    localparam int OTP_WIDTH = 64;
    localparam int OTP_POLE_LSB = 9;
    localparam int OTP_STAT_LSB = 12;
    localparam int OTP_EXTCLK_BIT = 14;
    localparam logic [5:0] READBACK_TOP = 6'h3d;
    localparam logic [3:0] PRE_STAT_DEG_0 = 4'h0;
    localparam logic [3:0] PRE_STAT_DEG_1 = 4'h2;
    localparam logic [3:0] PRE_STAT_DEG_2 = 4'h4;
    localparam logic [3:0] PRE_STAT_DEG_3 = 4'h8;

    // ****************************************
    // Register map
    // ****************************************
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam int CTRL_READBACK_BIT = 8;
    localparam logic [5:0] DYN_SHIFT_RESET = 6'h00;

    typedef enum {MODE_UVW, MODE_QUAD, MODE_STEP24, MODE_STEP60,
                  MODE_STEP90, MODE_STEP180} mode_type;

    typedef enum {ST_WAIT_OTP, ST_EXT_SYNC, ST_RUN} startup_type;

    typedef struct packed {
        logic com_inc;
        logic [3:0] strap;
    } strap_type;

    typedef struct packed {
        logic u_a;
        logic v_b;
        logic w_i;
        logic step;
    } outputs_type;

endpackage : angle_output_pkg

// ===== src/angle_output_encoder.sv
// The placing of the registers and the Wishbone interface to the registers were decided locally.
`timescale 1ns/1ps
module angle_output_encoder
    import angle_output_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic wb_ack_o,
    output logic [31:0] wb_dat_o,
    input wire logic [8:0] angle,
    input wire logic angle_error,
    input wire logic otp_ready,
    input wire logic [63:0] otp_word,
    input wire logic otp_check_flag,
    input wire logic otp_access,
    input wire logic com_inc,
    input wire logic [3:0] mode_strap,
    input wire logic dir,
    input wire logic iface_clk,
    output logic u_a,
    output logic v_b,
    output logic w_i,
    output logic step_out,
    output logic pwm_out,
    output logic program_pin_out,
    output logic program_pin_oe,
    output logic tracking_converter_reset
);

    // ****************************************
    // Pin synchronizers
    // ****************************************
    localparam int NPIN = 7;
    logic [NPIN-1:0] pin_raw;
    logic [NPIN-1:0] s1_ff;
    logic [NPIN-1:0] s2_ff;
    logic [NPIN-1:0] s3_ff;
    logic [NPIN-1:0] st_ff;
    logic [NPIN-1:0] nxt_st;
    assign pin_raw = {iface_clk, dir, com_inc, mode_strap};

    genvar g;
    generate
        for (g = 0; g < NPIN; g++) begin : g_sync
            // A change counts once stages two and three agree
            assign nxt_st[g] = (s2_ff[g] == s3_ff[g]) ? s3_ff[g] : st_ff[g];
            always_ff @(posedge mclk or negedge rst_n) begin
                if (!rst_n) begin
                    s1_ff[g] <= 1'b0;
                    s2_ff[g] <= 1'b0;
                    s3_ff[g] <= 1'b0;
                    st_ff[g] <= 1'b0;
                end else begin
                    s1_ff[g] <= pin_raw[g];
                    s2_ff[g] <= s1_ff[g];
                    s3_ff[g] <= s2_ff[g];
                    st_ff[g] <= nxt_st[g];
                end
            end
        end
    endgenerate

    // Edges count only once the stages hold real pin levels, so a pin
    // that idles high does not fake an edge right after reset
    logic [3:0] fill_ff;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            fill_ff <= 4'h0;
        end else begin
            fill_ff <= {fill_ff[2:0], 1'b1};
        end
    end
    wire sync_ok = fill_ff[3];

    wire ext_rise = sync_ok & nxt_st[4] & ~st_ff[4];
    wire ifc_rise = sync_ok & nxt_st[6] & ~st_ff[6];
    wire dir_now = nxt_st[5];
    wire dir_change = sync_ok & (nxt_st[5] ^ st_ff[5]);
    strap_type pins_now;
    assign pins_now = '{com_inc: nxt_st[4], strap: nxt_st[3:0]};

    // ****************************************
    // Startup and reset release
    // ****************************************
    startup_type state_ff;
    startup_type nxt_state;
    logic [2:0] sync_cnt_ff;
    mode_type mode_ff;
    mode_type nxt_mode;
    logic ext_mode_ff;
    logic conv_rst_ff;
    wire ext_en = otp_word[OTP_EXTCLK_BIT];

    always_comb begin
        case (pins_now.strap)
            4'h1: nxt_mode = MODE_STEP24;
            4'h2: nxt_mode = MODE_STEP60;
            4'h3: nxt_mode = MODE_STEP90;
            4'h4: nxt_mode = MODE_STEP180;
            default: nxt_mode = MODE_QUAD;
        endcase
        if (!pins_now.com_inc || ext_en) begin
            nxt_mode = MODE_UVW;
        end
    end

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_WAIT_OTP: begin
                if (otp_ready) begin
                    nxt_state = ext_en ? ST_EXT_SYNC : ST_RUN;
                end
            end
            ST_EXT_SYNC: begin
                // Counted on synchronized edges of the external clock
                if (ext_rise && sync_cnt_ff == 3'(EXT_SYNC_CYCLES - 1)) begin
                    nxt_state = ST_RUN;
                end
            end
            ST_RUN: nxt_state = ST_RUN;
            default: nxt_state = ST_WAIT_OTP;
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= ST_WAIT_OTP;
            sync_cnt_ff <= 3'h0;
            mode_ff <= MODE_UVW;
            ext_mode_ff <= 1'b0;
            conv_rst_ff <= 1'b1;
        end else begin
            state_ff <= nxt_state;
            if (state_ff == ST_EXT_SYNC && ext_rise) begin
                sync_cnt_ff <= sync_cnt_ff + 3'h1;
            end
            if (state_ff == ST_WAIT_OTP && otp_ready) begin
                mode_ff <= nxt_mode;
                ext_mode_ff <= ext_en;
            end
            conv_rst_ff <= (nxt_state != ST_RUN);
        end
    end

    wire running = (state_ff == ST_RUN);

    // ****************************************
    // Register bus
    // ****************************************
    logic ack_ff;
    logic [31:0] dat_ff;
    logic [5:0] dyn_ff;
    logic flag_valid_ff;
    wire bus_req = wb_cyc_i & wb_stb_i & ~ack_ff;
    wire wr_ctrl = bus_req & wb_we_i & (wb_adr_i == REG_CTRL);
    wire rb_start = wr_ctrl & wb_sel_i[1] & wb_dat_i[CTRL_READBACK_BIT];
    wire [31:0] ctrl_rd = {26'h0, dyn_ff};
    logic rb_busy_ff;
    logic [5:0] rb_idx_ff;
    wire [31:0] stat_rd = {15'h0, angle, 1'b0, running, rb_busy_ff,
                           3'(mode_ff), flag_valid_ff, otp_check_flag};
    wire [31:0] rd_mux = (wb_adr_i == REG_CTRL) ? ctrl_rd :
                         (wb_adr_i == REG_STATUS) ? stat_rd : 32'h0;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ack_ff <= 1'b0;
            dat_ff <= 32'h0;
        end else begin
            ack_ff <= bus_req;
            dat_ff <= bus_req ? rd_mux : 32'h0;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            dyn_ff <= DYN_SHIFT_RESET;
        end else if (dir_change) begin
            dyn_ff <= DYN_SHIFT_RESET;
        end else if (wr_ctrl && wb_sel_i[0]) begin
            dyn_ff <= wb_dat_i[5:0];
        end
    end

    // ****************************************
    // Stored-word check flag and readback
    // ****************************************
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            flag_valid_ff <= 1'b0;
        end else if (otp_access || rb_start) begin
            flag_valid_ff <= 1'b0;
        end else if (state_ff == ST_WAIT_OTP && otp_ready) begin
            flag_valid_ff <= 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rb_busy_ff <= 1'b0;
            rb_idx_ff <= READBACK_TOP;
        end else if (rb_start && !rb_busy_ff) begin
            rb_busy_ff <= 1'b1;
            rb_idx_ff <= READBACK_TOP;
        end else if (rb_busy_ff && ifc_rise) begin
            rb_busy_ff <= (rb_idx_ff != 6'h0);
            rb_idx_ff <= rb_idx_ff - 6'h1;
        end
    end

    // ****************************************
    // Commutation angle with shift
    // ****************************************
    wire [1:0] stat_code = otp_word[OTP_STAT_LSB +: 2];
    wire [3:0] stat_deg = (stat_code == 2'h0) ? PRE_STAT_DEG_0 :
                          (stat_code == 2'h1) ? PRE_STAT_DEG_1 :
                          (stat_code == 2'h2) ? PRE_STAT_DEG_2 :
                          PRE_STAT_DEG_3;
    wire [9:0] shift_tot = 10'(stat_deg) + 10'(dyn_ff);
    wire [9:0] ang_ext = {1'b0, angle};
    wire [9:0] ang_add = ang_ext + shift_tot;
    wire [9:0] ang_sub = ang_ext + 10'(ANGLE_STEPS) - shift_tot;
    wire [9:0] ang_add_w = (ang_add >= 10'(ANGLE_STEPS)) ?
                           ang_add - 10'(ANGLE_STEPS) : ang_add;
    wire [9:0] ang_sub_w = (ang_sub >= 10'(ANGLE_STEPS)) ?
                           ang_sub - 10'(ANGLE_STEPS) : ang_sub;
    wire [9:0] ang_com = dir_now ? ang_sub_w : ang_add_w;

    wire [2:0] pole_code = otp_word[OTP_POLE_LSB +: 3];
    wire [2:0] pole_pairs = (pole_code > 3'(MAX_POLE_PAIRS - 1)) ?
                            3'(MAX_POLE_PAIRS) : pole_code + 3'h1;
    wire [12:0] elec_raw = 13'(ang_com) * 13'(pole_pairs);
    wire [12:0] elec_mod = elec_raw % 13'(ANGLE_STEPS);
    wire [8:0] elec = elec_mod[8:0];
    wire com_u = elec < 9'(ELEC_HALF);
    wire com_v = (elec >= 9'(ELEC_THIRD)) && (elec < 9'(ELEC_FIVE_SIXTH));
    wire com_w = (elec < 9'(ELEC_SIXTH)) || (elec >= 9'(ELEC_TWO_THIRD));

    // ****************************************
    // Incremental and step signals
    // ****************************************
    wire quad_a = angle[1] ^ angle[0];
    wire quad_b = angle[1];
    wire index = (angle == 9'h0);
    wire [8:0] per = (mode_ff == MODE_STEP24) ? 9'(STEP_PER_24) :
                     (mode_ff == MODE_STEP60) ? 9'(STEP_PER_60) :
                     (mode_ff == MODE_STEP90) ? 9'(STEP_PER_90) :
                     9'(STEP_PER_180);
    wire [8:0] ph = angle % per;
    wire step_a = ph < (per >> 1);
    wire step_idx = angle < 9'(INDEX_WIDTH);
    wire step_sig = (step_a | step_idx) ^ pole_code[2];

    outputs_type nxt_out;
    outputs_type out_ff;
    always_comb begin
        nxt_out = '{u_a: 1'b0, v_b: 1'b0, w_i: 1'b0, step: 1'b0};
        if (running) begin
            case (mode_ff)
                MODE_UVW: begin
                    if (!angle_error) begin
                        nxt_out = '{u_a: com_u, v_b: com_v, w_i: com_w, step: 1'b0};
                    end
                end
                MODE_QUAD: begin
                    if (angle_error) begin
                        nxt_out = '{u_a: 1'b1, v_b: 1'b1, w_i: 1'b1, step: 1'b0};
                    end else begin
                        nxt_out = '{u_a: quad_a, v_b: quad_b, w_i: index, step: 1'b0};
                    end
                end
                MODE_STEP24, MODE_STEP60, MODE_STEP90, MODE_STEP180: begin
                    nxt_out.step = step_sig;
                end
                default: nxt_out.step = 1'b0;
            endcase
        end
    end

    // ****************************************
    // PWM frame
    // ****************************************
    logic [7:0] presc_ff;
    logic [8:0] pstep_ff;
    logic [8:0] high_ff;
    logic pwm_ff;
    wire int_tick = (presc_ff == 8'(PWM_STEP_CYC - 1));
    wire ptick = ext_mode_ff ? ext_rise : int_tick;
    wire frame_end = (pstep_ff == 9'(PWM_FRAME - 1));
    wire [8:0] nxt_high = angle_error ? 9'(PWM_ERR_HIGH) :
                          9'(PWM_ZERO_HIGH) + angle;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            presc_ff <= 8'h0;
            pstep_ff <= 9'h0;
            high_ff <= 9'(PWM_ZERO_HIGH);
            pwm_ff <= 1'b0;
        end else if (!running) begin
            presc_ff <= 8'h0;
            pstep_ff <= 9'h0;
            high_ff <= nxt_high;
            pwm_ff <= 1'b0;
        end else begin
            presc_ff <= int_tick ? 8'h0 : presc_ff + 8'h1;
            if (ptick) begin
                pstep_ff <= frame_end ? 9'h0 : pstep_ff + 9'h1;
                if (frame_end) begin
                    high_ff <= nxt_high;
                end
            end
            pwm_ff <= (pstep_ff < high_ff);
        end
    end

    // ****************************************
    // Output registers
    // ****************************************
    logic program_pin_out_ff;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            out_ff <= '{u_a: 1'b0, v_b: 1'b0, w_i: 1'b0, step: 1'b0};
            program_pin_out_ff <= 1'b0;
        end else begin
            out_ff <= nxt_out;
            program_pin_out_ff <= otp_word[rb_idx_ff];
        end
    end

    assign wb_ack_o = ack_ff;
    assign wb_dat_o = dat_ff;
    assign u_a = out_ff.u_a;
    assign v_b = out_ff.v_b;
    assign w_i = out_ff.w_i;
    assign step_out = out_ff.step;
    assign pwm_out = pwm_ff;
    assign program_pin_out = program_pin_out_ff;
    assign program_pin_oe = rb_busy_ff;
    assign tracking_converter_reset = conv_rst_ff;

endmodule : angle_output_encoder

// ===== test/angle_output_encoder_chk.sv
`timescale 1ns/1ps
module angle_output_encoder_chk
    import angle_output_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic wb_ack_o,
    input wire logic [31:0] wb_dat_o,
    input wire logic angle_error,
    input wire logic [63:0] otp_word,
    input wire logic com_inc,
    input wire logic iface_clk,
    input wire logic u_a,
    input wire logic v_b,
    input wire logic w_i,
    input wire logic step_out,
    input wire logic pwm_out,
    input wire logic program_pin_out,
    input wire logic program_pin_oe,
    input wire logic tracking_converter_reset
);
    // ****
    // Helper counters
    // ****
    logic [3:0] quiet_ff;
    logic [2:0] rises_ff;
    logic [16:0] high_ff;
    logic clk_d_ff;
    logic com_d_ff;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            quiet_ff <= 4'h0;
            rises_ff <= 3'h0;
            high_ff <= 17'h0;
            clk_d_ff <= 1'b0;
            com_d_ff <= 1'b1;
        end else begin
            clk_d_ff <= iface_clk;
            com_d_ff <= com_inc;
            quiet_ff <= (iface_clk != clk_d_ff) ? 4'h0 : ((quiet_ff == 4'hf) ? quiet_ff : quiet_ff + 4'h1);
            rises_ff <= (com_inc && !com_d_ff && rises_ff != 3'h7) ? rises_ff + 3'h1 : rises_ff;
            high_ff <= pwm_out ? high_ff + 17'h1 : 17'h0;
        end
    end
    // ****
    // Assertions
    // ****
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    AST_ACK_ONE: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("bus answer late");
    AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    AST_DAT_IDLE: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data outside ack");
    AST_ERR_OUT: assert property (angle_error && !tracking_converter_reset |=>
        ({u_a, v_b, w_i} == 3'h0) || ({u_a, v_b, w_i} == 3'h7))
        else $error("error pattern wrong");
    AST_STEP_EXCL: assert property (step_out |-> {u_a, v_b, w_i} == 3'h0)
        else $error("step with other pins high");
    AST_OE_CAUSE: assert property ($rose(program_pin_oe) |-> wb_ack_o && wb_we_i &&
        wb_adr_i == REG_CTRL && wb_dat_i[CTRL_READBACK_BIT])
        else $error("pin driven without command");
    AST_BIT_PACE: assert property (program_pin_oe && $past(program_pin_oe) &&
        $past(program_pin_oe, 2) && $changed(program_pin_out) |-> quiet_ff < 4'h8)
        else $error("readback bit moved without interface clock");
    AST_EXT_HOLD: assert property (otp_word[OTP_EXTCLK_BIT] && !tracking_converter_reset
        |-> rises_ff >= 3'h4)
        else $error("released before four external clocks");
    AST_PWM_SPAN: assert property ($fell(pwm_out) |-> high_ff >= PWM_ERR_HIGH * PWM_STEP_CYC
        && high_ff <= (PWM_ZERO_HIGH + PWM_LOW_SPAN) * PWM_STEP_CYC)
        else $error("pwm high time out of range");
endmodule : angle_output_encoder_chk

// ===== test/position_host_model.sv
`timescale 1ns/1ps
module position_host_model (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic pwm_out,
    output logic iface_clk,
    output logic [16:0] high_len,
    output logic [16:0] low_len,
    output logic [1:0] rises
);
    logic [16:0] run_ff;
    logic last_ff;
    initial iface_clk = 1'b0;
    // Capture timer on the PWM pin, as a controller would measure it
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            run_ff <= 17'h0;
            last_ff <= 1'b0;
            high_len <= 17'h0;
            low_len <= 17'h0;
            rises <= 2'h0;
        end else begin
            last_ff <= pwm_out;
            run_ff <= (pwm_out == last_ff) ? run_ff + 17'h1 : 17'h1;
            if (last_ff && !pwm_out) high_len <= run_ff;
            if (!last_ff && pwm_out) low_len <= run_ff;
            if (!last_ff && pwm_out && rises != 2'h3) rises <= rises + 2'h1;
        end
    end
    // One slow interface clock pulse, idle low between pulses
    task automatic pulse_iface();
        iface_clk <= 1'b1;
        repeat (6) @(posedge mclk);
        iface_clk <= 1'b0;
        repeat (6) @(posedge mclk);
    endtask : pulse_iface
endmodule : position_host_model

// ===== test/angle_output_encoder_test.sv
`timescale 1ns/1ps
module angle_output_encoder_test import angle_output_pkg::*;;
    logic mclk, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, iface_clk;
    logic [3:0] wb_adr_i, wb_sel_i, mode_strap;
    logic [31:0] wb_dat_i, wb_dat_o, rd;
    logic [8:0] angle;
    logic [63:0] otp_word;
    logic angle_error, otp_ready, otp_check_flag, otp_access, com_inc, dir;
    logic u_a, v_b, w_i, step_out, pwm_out, program_pin_out, program_pin_oe, tracking_converter_reset;
    logic [16:0] high_len, low_len;
    logic [1:0] rises;
    int miscompares = 0;
    int n_tests = 0;
    angle_output_encoder i_dut (.mclk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
        .wb_dat_i, .wb_ack_o, .wb_dat_o, .angle, .angle_error, .otp_ready, .otp_word, .otp_check_flag,
        .otp_access, .com_inc, .mode_strap, .dir, .iface_clk, .u_a, .v_b, .w_i, .step_out, .pwm_out,
        .program_pin_out, .program_pin_oe, .tracking_converter_reset);
    position_host_model i_host (.mclk, .rst_n, .pwm_out, .iface_clk, .high_len, .low_len, .rises);
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    // ****
    // Shared tasks
    // ****
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic bus(input logic we, input logic [3:0] adr, input logic [31:0] wdat);
        @(posedge mclk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_sel_i <= 4'hf;
        wb_dat_i <= wdat;
        do begin
            @(posedge mclk);
        end while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask : bus
    task automatic start(input logic com, input logic [3:0] strap, input logic [63:0] otp);
        @(posedge mclk);
        rst_n <= 1'b0;
        otp_ready <= 1'b0;
        com_inc <= com;
        mode_strap <= strap;
        otp_word <= otp;
        repeat (8) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (6) @(posedge mclk);
        otp_ready <= 1'b1;
        repeat (6) @(posedge mclk);
    endtask : start
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : print_verdict
    // ****
    // Scenarios
    // ****
    task automatic t_status();
        start(1'b1, 4'h0, 64'h0);
        bus(1'b0, REG_STATUS, 32'h0);
        chk(rd[1:0], 2'h3);
        otp_access <= 1'b1;
        @(posedge mclk);
        otp_access <= 1'b0;
        bus(1'b0, REG_STATUS, 32'h0);
        chk(rd[1], 1'b0);
        bus(1'b0, 4'h8, 32'h0);
        chk(rd, 32'h0);
        otp_check_flag <= 1'b0;
        start(1'b1, 4'h0, 64'h0);
        bus(1'b0, REG_STATUS, 32'h0);
        chk(rd[1:0], 2'h2);
        $display("status test done");
    endtask : t_status
    task automatic t_modes();
        logic [2:0] m;
        for (int i = 0; i < 17; i++) begin
            m = (i == 16) ? 3'h0 : ((i >= 1 && i <= 4) ? 3'(i + 1) : 3'h1);
            start(i < 16, i[3:0], 64'h0);
            bus(1'b0, REG_STATUS, 32'h0);
            chk({rd[6], rd[4:2]}, {1'b1, m});
            @(negedge mclk);
            if (m == 3'h1) chk({u_a, v_b, w_i, step_out}, 4'h8);
            else if (m == 3'h0) chk(step_out, 1'b0);
            else chk({u_a, v_b, w_i}, 3'h0);
        end
        @(posedge mclk);
        com_inc <= 1'b1;
        mode_strap <= 4'h1;
        repeat (10) @(posedge mclk);
        bus(1'b0, REG_STATUS, 32'h0);
        chk(rd[4:2], 3'h0);
        $display("mode test done");
    endtask : t_modes
    task automatic t_quad();
        int first_a = 99;
        int first_b = 99;
        start(1'b1, 4'h0, 64'h0);
        for (int k = 0; k < 8; k++) begin
            @(posedge mclk);
            angle <= 9'(k);
            repeat (2) @(negedge mclk);
            if (k < 2) chk(w_i, k == 0);
            if (u_a === 1'b1 && first_a == 99) first_a = k;
            if (v_b === 1'b1 && first_b == 99) first_b = k;
        end
        chk(first_a < first_b, 1'b1);
        @(posedge mclk);
        angle_error <= 1'b1;
        repeat (2) @(negedge mclk);
        chk({u_a, v_b, w_i}, 3'h7);
        @(posedge mclk);
        angle_error <= 1'b0;
        angle <= 9'd0;
        $display("quadrature test done");
    endtask : t_quad
    task automatic t_dir();
        start(1'b0, 4'h0, 64'h3000);
        bus(1'b1, REG_CTRL, 32'h5);
        bus(1'b0, REG_CTRL, 32'h0);
        chk(rd[5:0], 6'h5);
        @(negedge mclk);
        chk(u_a, 1'b1);
        @(posedge mclk);
        dir <= 1'b1;
        repeat (4) @(negedge mclk);
        chk(u_a, 1'b1);
        @(negedge mclk);
        chk(u_a, 1'b0);
        bus(1'b0, REG_CTRL, 32'h0);
        chk(rd[5:0], 6'h0);
        dir <= 1'b0;
        $display("direction test done");
    endtask : t_dir
    task automatic t_ext();
        int n = 0;
        start(1'b1, 4'h1, 64'h4000);
        for (int k = 0; k < 4; k++) begin
            @(negedge mclk);
            chk(tracking_converter_reset, 1'b1);
            @(posedge mclk);
            com_inc <= 1'b0;
            repeat (5) @(posedge mclk);
            com_inc <= 1'b1;
            repeat (5) @(posedge mclk);
        end
        while (tracking_converter_reset !== 1'b0 && n < 20) begin
            @(negedge mclk);
            n++;
        end
        chk(n < 20, 1'b1);
        bus(1'b0, REG_STATUS, 32'h0);
        chk({rd[6], rd[4:2]}, 4'h8);
        $display("external clock test done");
    endtask : t_ext
    task automatic t_readback();
        start(1'b1, 4'h0, 64'h2c00_0000_0000_0000);
        bus(1'b1, REG_CTRL, 32'h100);
        @(negedge mclk);
        chk(program_pin_oe, 1'b1);
        for (int k = 0; k < 3; k++) begin
            @(negedge mclk);
            chk(program_pin_out, otp_word[61 - k]);
            @(posedge mclk);
            i_host.pulse_iface();
        end
        $display("readback test done");
    endtask : t_readback
    task automatic t_pwm();
        int n = 0;
        start(1'b0, 4'h0, 64'h0);
        while (rises < 2'h2 && n < 80000) begin
            @(posedge mclk);
            n++;
        end
        @(negedge mclk);
        chk(n < 80000, 1'b1);
        chk(high_len, PWM_ZERO_HIGH * PWM_STEP_CYC);
        chk(low_len, (PWM_LOW_SPAN + PWM_EXIT) * PWM_STEP_CYC);
        $display("pwm test done");
    endtask : t_pwm
    initial begin
        rst_n = 1'b0;
        {wb_cyc_i, wb_stb_i, wb_we_i, otp_ready, otp_access, com_inc, dir, angle_error} = 8'h0;
        {wb_adr_i, wb_sel_i, mode_strap, wb_dat_i} = 44'h0;
        angle = 9'd5;
        otp_word = 64'h0;
        otp_check_flag = 1'b1;
        t_status();
        t_modes();
        t_quad();
        t_dir();
        t_ext();
        t_readback();
        t_pwm();
        print_verdict();
    end
    // Room for one full PWM frame after the short register tests
    initial begin
        #(95000 * 10);
        miscompares++;
        print_verdict();
    end
endmodule : angle_output_encoder_test
bind angle_output_encoder angle_output_encoder_chk i_chk (.mclk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_dat_i, .wb_ack_o, .wb_dat_o, .angle_error, .otp_word, .com_inc, .iface_clk, .u_a, .v_b,
    .w_i, .step_out, .pwm_out, .program_pin_out, .program_pin_oe, .tracking_converter_reset);
